// ### verilog/srtc_defs.svh
`ifndef SRTC_DEFS_SVH
`define SRTC_DEFS_SVH
// ============================================================
// bus identity and memory map
`define SRTC_SLAVE_ID 7'h68
`define SRTC_RAM_TOP 15'h7fef
`define SRTC_RSV_LO 15'h7ff0
`define SRTC_CLK_BASE 15'h7ff7
`define SRTC_OFS_SUB_SECOND 15'h7ff7
`define SRTC_OFS_CAL_WRITE 15'h7ff8
`define SRTC_OFS_SECONDS 15'h7ff9
`define SRTC_OFS_MINUTES 15'h7ffa
`define SRTC_OFS_HOURS 15'h7ffb
`define SRTC_OFS_WEEKDAY 15'h7ffc
`define SRTC_OFS_DATE 15'h7ffd
`define SRTC_OFS_MONTH 15'h7ffe
`define SRTC_OFS_YEAR 15'h7fff
// ============================================================
// field positions and reset values
`define SRTC_WRITE_BIT 7
`define SRTC_RST_ZERO 8'h00
`define SRTC_RST_ONE 8'h01
// ============================================================
// timing
`define SRTC_CLK_PERIOD_NS 20
`define SRTC_REC_NS 200000
`define SRTC_OSC_HZ 16'h8000
`define SRTC_TICK_STEP 16'h0064
`endif

// ### verilog/srtc_pkg.sv
`default_nettype none
package srtc_pkg;
	// ============================================================
	// serial engine states, one-hot
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_RECV = 6'h02,
		ST_RACK = 6'h04,
		ST_SEND = 6'h08,
		ST_TACK = 6'h10,
		ST_IGNORE = 6'h20
	} srtc_state_t;
	// meaning of the byte being received, one-hot
	typedef enum logic [4:0] {
		K_SLAVE = 5'h01,
		K_ADDR_HI = 5'h02,
		K_ADDR_LO = 5'h04,
		K_DATA = 5'h08,
		K_READ = 5'h10
	} srtc_kind_t;
	// one pending byte write
	typedef struct packed {
		logic [14:0] addr;
		logic [7:0] data;
	} srtc_wr_t;
endpackage : srtc_pkg
`default_nettype wire

// ### verilog/srtc_slave.sv
`include "srtc_defs.svh"
`default_nettype none
// How it works
// (R1) only a slave; answers the slave address d0h after a start
// (R2) 0..7fef is plain ram; 7ff0..7ff6 reserved, read zero, writes dropped
// (R3) clock registers at 7ff7..7fff: sub-second, control, sec, min, hour, day, date, month, year
// (R4) 7ff8 keeps calibration plus the write bit that freezes counting
// (R5) pointer advances by one after every data byte read or written
// (R6) calendar counts in bcd, hours in 24-hour form
// (R7) month lengths 28/29/30/31, leap years right through 2099
// (R8) time base is the 32.768 khz oscillator, not the serial clock
// (R9) power fail abandons the access and clears the pointer
// (R10) while supply is bad all bus inputs are ignored
// (R11) write protect lasts a recovery interval after supply returns
// (R12) master starts transfers only on an idle bus
// (R13) idle bus means both lines high
// (R14) data falling while clock high is start
// (R15) data rising while clock high is stop and ends the transfer
// (R16) transmitter changes data only while clock is low
// (R17) data edges under high clock are controls, never data
// (R18) transfers framed by start and stop, any number of bytes
// (R19) eight-bit bytes, receiver acknowledges on a ninth clock
// (R20) pointer wraps from the top address to zero
// (R21) pointer advances on the acknowledge clock only
// (R22) two address bytes after a write address, high first, top bit ignored
// (R23) master ends a read with no acknowledge; device releases data high
// (R24) pointer is 15 bits and survives between transfers
// (R25) foreign slave address is not acknowledged; line stays released

// ============================================================
// write buffer
module srtc_fifo #(
	parameter int WIDTH = 23,
	parameter int DEPTH = 32
) (
	// clock and reset
	input wire logic clock,
	input wire logic rstN,
	// filling side
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	// draining side
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] store [0:DEPTH-1];
	logic [AW:0] wrPtr;
	logic [AW:0] rdPtr;

	// extra pointer bit tells full from empty
	assign inReady = (wrPtr ^ rdPtr) != {1'b1, {AW{1'b0}}};
	assign outValid = wrPtr != rdPtr;
	assign outData = store[rdPtr[AW-1:0]];

	// pointers
	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			wrPtr <= '0;
			rdPtr <= '0;
		end else begin
			if (inValid && inReady) begin
				wrPtr <= wrPtr + 1'b1;
			end
			if (outValid && outReady) begin
				rdPtr <= rdPtr + 1'b1;
			end
		end
	end

	// storage has no reset, only valid words are ever read
	always_ff @(posedge clock) begin
		if (inValid && inReady) begin
			store[wrPtr[AW-1:0]] <= inData;
		end
	end
endmodule : srtc_fifo

// ============================================================
// serial clock/calendar memory slave
module srtc_slave import srtc_pkg::*; #(
	parameter int RECOVERY_CYC = (`SRTC_REC_NS + `SRTC_CLK_PERIOD_NS - 1) / `SRTC_CLK_PERIOD_NS,
	parameter int FIFO_DEPTH = 32
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// two-wire bus
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe_b,
	// time base and supply monitor
	input wire logic oscIn,
	input wire logic supplyOk,
	// status
	output logic writeProtect,
	output logic busIdle
);
	localparam int I_SUB = 32'(`SRTC_OFS_SUB_SECOND - `SRTC_CLK_BASE);
	localparam int I_CAL = 32'(`SRTC_OFS_CAL_WRITE - `SRTC_CLK_BASE);
	localparam int I_SEC = 32'(`SRTC_OFS_SECONDS - `SRTC_CLK_BASE);
	localparam int I_MIN = 32'(`SRTC_OFS_MINUTES - `SRTC_CLK_BASE);
	localparam int I_HOUR = 32'(`SRTC_OFS_HOURS - `SRTC_CLK_BASE);
	localparam int I_DAY = 32'(`SRTC_OFS_WEEKDAY - `SRTC_CLK_BASE);
	localparam int I_DATE = 32'(`SRTC_OFS_DATE - `SRTC_CLK_BASE);
	localparam int I_MON = 32'(`SRTC_OFS_MONTH - `SRTC_CLK_BASE);
	localparam int I_YEAR = 32'(`SRTC_OFS_YEAR - `SRTC_CLK_BASE);

	logic [1:0] rstSync;
	logic rstN;
	logic [1:0] sclSync, sdaSync, oscSync, pwrSync;
	logic sclPrev, sdaPrev, oscPrev;
	logic sclS, sdaS, pwrS;
	logic sclRise, sclFall, startCond, stopCond, oscRise;
	srtc_state_t state;
	srtc_kind_t kind;
	logic [3:0] bitCnt;
	logic [7:0] shiftIn, txShift, rdData, rdByte;
	logic [14:0] ptr;
	logic sdaLow, ackSeen, ackInc, protect;
	logic [31:0] recCnt;
	logic pushValid, fifoReady, drainValid, drainReady;
	srtc_wr_t pushEntry, drainEntry;
	logic [7:0] mem [0:32767];
	logic [7:0] clkReg [0:8];
	logic [7:0] nextClk [0:8];
	logic [15:0] tickAcc;
	logic tickPend, drainClk;
	logic rollSub, rollSec, rollMin, rollHour, rollDate, rollMonth;

	// ============================================================
	// helpers
	function automatic logic [7:0] bcdInc(input logic [7:0] v);
		bcdInc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
	endfunction : bcdInc

	function automatic logic [7:0] bcdStep(input logic [7:0] v, input logic [7:0] last,
			input logic [7:0] first);
		bcdStep = (v == last) ? first : bcdInc(v);
	endfunction : bcdStep

	// last date of a month; every fourth year leaps, right for 2000..2099
	function automatic logic [7:0] monthEnd(input logic [7:0] mon, input logic [7:0] yr);
		logic leap;
		leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
			: (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
		case (mon)
			8'h02: monthEnd = leap ? 8'h29 : 8'h28; // R7
			8'h04, 8'h06, 8'h09, 8'h11: monthEnd = 8'h30;
			default: monthEnd = 8'h31;
		endcase
	endfunction : monthEnd

	// ============================================================
	// reset release and pin synchronisers
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rstSync <= 2'h0;
		end else begin
			rstSync <= {rstSync[0], 1'b1};
		end
	end
	assign rstN = rstSync[1];

	// all pins come from outside, two flops before any logic looks
	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			sclSync <= 2'h3;
			sdaSync <= 2'h3;
			oscSync <= 2'h0;
			pwrSync <= 2'h0;
			sclPrev <= 1'b1;
			sdaPrev <= 1'b1;
			oscPrev <= 1'b0;
		end else begin
			sclSync <= {sclSync[0], sclIn};
			sdaSync <= {sdaSync[0], sdaIn};
			oscSync <= {oscSync[0], oscIn};
			pwrSync <= {pwrSync[0], supplyOk};
			sclPrev <= sclSync[1];
			sdaPrev <= sdaSync[1];
			oscPrev <= oscSync[1];
		end
	end
	assign sclS = sclSync[1];
	assign sdaS = sdaSync[1];
	assign pwrS = pwrSync[1];
	assign sclRise = sclS && !sclPrev;
	assign sclFall = !sclS && sclPrev;
	assign startCond = sclS && sclPrev && sdaPrev && !sdaS; // R14 R17
	assign stopCond = sclS && sclPrev && !sdaPrev && sdaS; // R15 R17
	assign oscRise = oscSync[1] && !oscPrev;

	// ============================================================
	// supply watch: protect at once, release after the recovery count
	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			protect <= 1'b1;
			recCnt <= '0;
		end else if (!pwrS) begin
			protect <= 1'b1;
			recCnt <= '0;
		end else if (protect) begin
			if (recCnt >= 32'(RECOVERY_CYC - 1)) begin
				protect <= 1'b0; // R11
			end else begin
				recCnt <= recCnt + 32'h1;
			end
		end
	end

	// status outputs
	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			writeProtect <= 1'b1;
			busIdle <= 1'b0;
		end else begin
			writeProtect <= protect;
			busIdle <= sclS && sdaS && (state == ST_IDLE) && !protect; // R13 R12
		end
	end

	// ============================================================
	// read path: ram is read one cycle after the pointer settles
	always_ff @(posedge clock) begin
		rdData <= mem[ptr];
	end

	always_comb begin
		if (ptr >= `SRTC_CLK_BASE) begin
			rdByte = clkReg[ptr[3:0] - 4'h7]; // R3
		end else if (ptr >= `SRTC_RSV_LO) begin
			rdByte = 8'h00; // R2
		end else begin
			rdByte = rdData; // R2
		end
	end

	// ============================================================
	// serial engine
	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			state <= ST_IDLE;
			kind <= K_SLAVE;
			bitCnt <= 4'h0;
			shiftIn <= 8'h00;
			txShift <= 8'h00;
			sdaLow <= 1'b0;
			ackSeen <= 1'b0;
			ackInc <= 1'b0;
			ptr <= '0;
			pushValid <= 1'b0;
			pushEntry <= '0;
		end else begin
			pushValid <= 1'b0;
			if (protect) begin
				state <= ST_IDLE; // R9 R10
				sdaLow <= 1'b0;
				ackInc <= 1'b0;
				ptr <= '0; // R9
			end else if (startCond) begin
				state <= ST_RECV; // R18
				kind <= K_SLAVE;
				bitCnt <= 4'h0;
				sdaLow <= 1'b0;
				ackInc <= 1'b0;
			end else if (stopCond) begin
				state <= ST_IDLE; // R15
				sdaLow <= 1'b0;
				ackInc <= 1'b0;
			end else begin
				case (state)
					ST_RECV: begin
						if (sclRise) begin
							shiftIn <= {shiftIn[6:0], sdaS};
							bitCnt <= bitCnt + 4'h1;
						end else if (sclFall && bitCnt == 4'h8) begin // R19
							bitCnt <= 4'h0;
							state <= ST_RACK;
							sdaLow <= 1'b1; // R16
							case (kind)
								K_SLAVE: begin
									if (shiftIn[7:1] == `SRTC_SLAVE_ID) begin // R1
										kind <= shiftIn[0] ? K_READ : K_ADDR_HI;
									end else begin
										state <= ST_IGNORE; // R25
										sdaLow <= 1'b0;
									end
								end
								K_ADDR_HI: begin
									ptr[14:8] <= shiftIn[6:0]; // R22 R24
									kind <= K_ADDR_LO;
								end
								K_ADDR_LO: begin
									ptr[7:0] <= shiftIn; // R22
									kind <= K_DATA;
								end
								default: begin
									if (fifoReady) begin
										pushValid <= 1'b1;
										pushEntry <= '{addr: ptr, data: shiftIn};
										ackInc <= 1'b1;
									end else begin
										state <= ST_IGNORE; // full buffer refuses the byte
										sdaLow <= 1'b0;
									end
								end
							endcase
						end
					end
					ST_RACK: begin
						if (sclFall) begin
							ackInc <= 1'b0;
							if (ackInc) begin
								ptr <= ptr + 15'h1; // R5 R20 R21
							end
							if (kind == K_READ) begin
								sdaLow <= ~rdByte[7]; // R16
								txShift <= {rdByte[6:0], 1'b0};
								bitCnt <= 4'h1;
								state <= ST_SEND;
							end else begin
								sdaLow <= 1'b0;
								state <= ST_RECV;
							end
						end
					end
					ST_SEND: begin
						if (sclFall) begin
							if (bitCnt == 4'h8) begin
								sdaLow <= 1'b0; // R19
								state <= ST_TACK;
							end else begin
								sdaLow <= ~txShift[7]; // R16
								txShift <= {txShift[6:0], 1'b0};
								bitCnt <= bitCnt + 4'h1;
							end
						end
					end
					ST_TACK: begin
						if (sclRise) begin
							ackSeen <= !sdaS;
							ptr <= ptr + 15'h1; // R5 R20 R21
						end else if (sclFall) begin
							if (ackSeen) begin
								sdaLow <= ~rdByte[7];
								txShift <= {rdByte[6:0], 1'b0};
								bitCnt <= 4'h1;
								state <= ST_SEND;
							end else begin
								state <= ST_IGNORE; // R23
							end
						end
					end
					default: begin
						sdaLow <= 1'b0; // idle and ignore keep the line released
					end
				endcase
			end
		end
	end

	// open drain: only ever pulls low
	assign sdaOut = 1'b0;
	assign sdaOe_b = ~sdaLow;

	// ============================================================
	// write buffer between the bus and the storage
	srtc_fifo #(
		.WIDTH($bits(srtc_wr_t)),
		.DEPTH(FIFO_DEPTH)
	) writeBuf (
		.clock(clock),
		.rstN(rstN),
		.inValid(pushValid),
		.inReady(fifoReady),
		.inData(pushEntry),
		.outValid(drainValid),
		.outReady(drainReady),
		.outData(drainEntry)
	);

	// a clock write waits while a tick is pending so the tick is never lost
	assign drainClk = drainEntry.addr >= `SRTC_CLK_BASE;
	assign drainReady = !(drainClk && tickPend);

	always_ff @(posedge clock) begin
		if (drainValid && drainReady && drainEntry.addr <= `SRTC_RAM_TOP) begin
			mem[drainEntry.addr] <= drainEntry.data; // R2
		end
	end

	// ============================================================
	// time base: 100 ticks per 32768 oscillator edges, exact on average
	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			tickAcc <= 16'h0000;
			tickPend <= 1'b0;
		end else begin
			if (oscRise) begin // R8
				if (tickAcc + `SRTC_TICK_STEP >= `SRTC_OSC_HZ) begin
					tickAcc <= tickAcc + `SRTC_TICK_STEP - `SRTC_OSC_HZ;
					tickPend <= 1'b1;
				end else begin
					tickAcc <= tickAcc + `SRTC_TICK_STEP;
					tickPend <= 1'b0;
				end
			end else begin
				tickPend <= 1'b0; // consumed by the counters this cycle
			end
		end
	end

	// calendar carry chain
	assign rollSub = clkReg[I_SUB] == 8'h99;
	assign rollSec = rollSub && clkReg[I_SEC] == 8'h59;
	assign rollMin = rollSec && clkReg[I_MIN] == 8'h59;
	assign rollHour = rollMin && clkReg[I_HOUR] == 8'h23; // R6
	assign rollDate = rollHour && clkReg[I_DATE] == monthEnd(clkReg[I_MON], clkReg[I_YEAR]);
	assign rollMonth = rollDate && clkReg[I_MON] == 8'h12;

	always_comb begin
		for (int i = 0; i < 9; i++) begin
			nextClk[i] = clkReg[i];
		end
		nextClk[I_SUB] = bcdStep(clkReg[I_SUB], 8'h99, 8'h00); // R6
		if (rollSub) begin
			nextClk[I_SEC] = bcdStep(clkReg[I_SEC], 8'h59, 8'h00);
		end
		if (rollSec) begin
			nextClk[I_MIN] = bcdStep(clkReg[I_MIN], 8'h59, 8'h00);
		end
		if (rollMin) begin
			nextClk[I_HOUR] = bcdStep(clkReg[I_HOUR], 8'h23, 8'h00);
		end
		if (rollHour) begin
			nextClk[I_DAY][2:0] = (clkReg[I_DAY][2:0] == 3'h7) ? 3'h1 : clkReg[I_DAY][2:0] + 3'h1;
			nextClk[I_DATE] = rollDate ? 8'h01 : bcdInc(clkReg[I_DATE]); // R7
		end
		if (rollDate) begin
			nextClk[I_MON] = bcdStep(clkReg[I_MON], 8'h12, 8'h01);
		end
		if (rollMonth) begin
			nextClk[I_YEAR] = bcdStep(clkReg[I_YEAR], 8'h99, 8'h00);
		end
	end

	// clock registers: tick first, bus writes when no tick is pending
	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			for (int i = 0; i < 9; i++) begin
				clkReg[i] <= `SRTC_RST_ZERO;
			end
			clkReg[I_DAY] <= `SRTC_RST_ONE;
			clkReg[I_DATE] <= `SRTC_RST_ONE;
			clkReg[I_MON] <= `SRTC_RST_ONE;
		end else if (tickPend) begin
			if (!clkReg[I_CAL][`SRTC_WRITE_BIT]) begin // R4
				for (int i = 0; i < 9; i++) begin
					clkReg[i] <= nextClk[i];
				end
			end
		end else if (drainValid && drainClk) begin
			clkReg[drainEntry.addr[3:0] - 4'h7] <= drainEntry.data; // R3 R4
		end
	end
endmodule : srtc_slave
`default_nettype wire

// ### tb/srtc_slave_checker.sv
`default_nettype none
// ========
// pin-level checks on the clock/calendar slave
module srtc_slave_checker #(
	parameter int RECOVERY_CYC = 20,
	parameter int FIFO_DEPTH = 32
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// bus pins
	input wire logic sclIn,
	input wire logic sdaIn,
	input wire logic sdaOut,
	input wire logic sdaOe_b,
	// time base, supply and status
	input wire logic oscIn,
	input wire logic supplyOk,
	input wire logic writeProtect,
	input wire logic busIdle
);
	timeunit 1ns;
	timeprecision 1ps;
	int okCnt;
	// good-supply run length; saturates at RECOVERY_CYC + 12, so the late bound is checked on every cycle from then on
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			okCnt <= 0;
		end else if (!supplyOk) begin
			okCnt <= 0;
		end else if (okCnt < RECOVERY_CYC + 12) begin
			okCnt <= okCnt + 1;
		end
	end
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rst_b);
	chk_fail_protect: assert property (!supplyOk |-> ##[1:4] writeProtect)
		else $error("protect not raised on supply loss");
	chk_protect_quiet: assert property (writeProtect [*4] |-> sdaOe_b)
		else $error("data driven while protected");
	chk_protect_busy: assert property (writeProtect |-> !busIdle)
		else $error("idle reported while protected");
	chk_recovery_early: assert property ($fell(writeProtect) |-> okCnt >= RECOVERY_CYC)
		else $error("protect dropped before recovery");
	chk_recovery_late: assert property (okCnt == RECOVERY_CYC + 12 |-> !writeProtect)
		else $error("protect held too long");
	chk_idle_quiet: assert property (busIdle |-> sdaOe_b)
		else $error("data driven on idle bus");
	chk_start_busy: assert property (sclIn && $fell(sdaIn) && busIdle |-> ##[1:4] !busIdle)
		else $error("start not seen");
	chk_stop_idle: assert property (sclIn && $rose(sdaIn) && !writeProtect |-> ##[1:5] busIdle)
		else $error("stop did not idle the bus");
	chk_drive_clock_low: assert property ($changed(sdaOe_b) && !writeProtect |-> !sclIn)
		else $error("data changed while clock high");
	// main scenarios reached
	cover property (sclIn && $fell(sdaIn));
	cover property ($fell(sdaOe_b));
	cover property ($rose(writeProtect));
endmodule : srtc_slave_checker

bind srtc_slave srtc_slave_checker #(.RECOVERY_CYC(RECOVERY_CYC), .FIFO_DEPTH(FIFO_DEPTH)) chk_u (
	.clock(clock), .rst_b(rst_b), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
	.sdaOe_b(sdaOe_b), .oscIn(oscIn), .supplyOk(supplyOk), .writeProtect(writeProtect),
	.busIdle(busIdle));
`default_nettype wire

// ### tb/srtc_bus_master.sv
`default_nettype none
// ========
// two-wire master; lines move only on system clock edges, 8 clocks per bus clock
module srtc_bus_master (
	// clock
	input wire logic clock,
	// bus; data is pulled up, so a release reads back as one
	input wire logic sdaLine,
	output logic scl,
	output logic sdaLow
);
	timeunit 1ns;
	timeprecision 1ps;
	// bus clock stands high between frames
	initial begin
		scl = 1'b1;
		sdaLow = 1'b0;
	end
	task automatic hold(input int n);
		repeat (n) @(posedge clock);
	endtask : hold
	// start or repeated start; from idle both lines are high first
	task automatic busStart();
		sdaLow <= 1'b0;
		hold(4);
		scl <= 1'b1;
		hold(4);
		sdaLow <= 1'b1;
		hold(4);
		scl <= 1'b0;
	endtask : busStart
	// data set mid-low so it is stable over the whole high phase
	task automatic bitXfer(input logic b, output logic seen);
		hold(2);
		sdaLow <= ~b;
		hold(2);
		scl <= 1'b1;
		hold(2);
		seen = sdaLine;
		hold(2);
		scl <= 1'b0;
	endtask : bitXfer
	// eight bits msb first, then the acknowledge clock
	task automatic xferByte(input logic [7:0] tx, input logic ninth, output logic [7:0] rx,
		output logic seen9);
		for (int i = 7; i >= 0; i--) bitXfer(tx[i], rx[i]);
		bitXfer(ninth, seen9);
	endtask : xferByte
	task automatic busStop();
		hold(2);
		sdaLow <= 1'b1;
		hold(2);
		scl <= 1'b1;
		hold(4);
		sdaLow <= 1'b0;
		hold(4);
	endtask : busStop
endmodule : srtc_bus_master
`default_nettype wire

// ### tb/tb.sv
`default_nettype none
// ========
// self-checking bench for the clock/calendar slave
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int RCY = 20;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic oscIn = 1'b0;
	logic supplyOk = 1'b1;
	logic sclIn;
	logic sdaLow;
	logic sdaOut;
	logic sdaOe_b;
	logic writeProtect;
	logic busIdle;
	int oscDiv = 0;
	int badCount = 0;
	int numChecks = 0;
	// wired-and data line with pull-up
	wire logic sdaLine = !sdaLow && (sdaOe_b ? 1'b1 : sdaOut);
	// 50 mhz system clock
	always #10 clock = ~clock;
	// time base far faster than 32.768 khz, so a hundredth ticks about every 1300 clocks
	always @(posedge clock) begin
		oscDiv <= (oscDiv == 1) ? 0 : oscDiv + 1;
		if (oscDiv == 1) begin
			oscIn <= ~oscIn;
		end
	end
	srtc_slave #(.RECOVERY_CYC(RCY), .FIFO_DEPTH(32)) dut_u (.clock(clock), .rst_b(rst_b),
		.sclIn(sclIn), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe_b(sdaOe_b), .oscIn(oscIn),
		.supplyOk(supplyOk), .writeProtect(writeProtect), .busIdle(busIdle));
	srtc_bus_master mst_u (.clock(clock), .sdaLine(sdaLine), .scl(sclIn), .sdaLow(sdaLow));
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		numChecks++;
		if (got !== exp) begin
			badCount++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic flag(input logic got, input logic exp);
		check({15'h0, got}, {15'h0, exp});
	endtask : flag
	task automatic sendB(input logic [7:0] b, input logic expNack);
		logic [7:0] rx;
		logic nack;
		mst_u.xferByte(b, 1'b1, rx, nack);
		flag(nack, expNack);
	endtask : sendB
	task automatic setPtr(input logic [7:0] hi, input logic [7:0] lo);
		mst_u.busStart();
		sendB(8'hd0, 1'b0);
		sendB(hi, 1'b0);
		sendB(lo, 1'b0);
	endtask : setPtr
	task automatic writeAt(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] q[$]);
		setPtr(hi, lo);
		foreach (q[i]) sendB(q[i], 1'b0);
		mst_u.busStop();
	endtask : writeAt
	// read from the current pointer, last byte not acknowledged
	task automatic readNext(input logic [7:0] q[$]);
		logic [7:0] rx;
		logic seen;
		mst_u.busStart();
		sendB(8'hd1, 1'b0);
		foreach (q[i]) begin
			mst_u.xferByte(8'hff, i == q.size() - 1, rx, seen);
			check({8'h0, rx}, {8'h0, q[i]});
		end
		mst_u.busStop();
	endtask : readNext
	task automatic printVerdict();
		if (badCount == 0 && numChecks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : printVerdict
	// cuts a hang short well beyond the expected run
	initial begin
		#1000000;
		badCount++;
		printVerdict();
	end
	// main sequence
	initial begin
		int cnt;
		repeat (5) @(posedge clock);
		rst_b <= 1'b1;
		@(negedge clock);
		flag(writeProtect, 1'b1);
		flag(busIdle, 1'b0);
		for (cnt = 0; cnt < 200 && busIdle !== 1'b1; cnt++) @(negedge clock);
		flag(busIdle, 1'b1);
		// top address bit ignored, repeated start into a read
		writeAt(8'h81, 8'h23, '{8'ha5, 8'h5a});
		setPtr(8'h01, 8'h23);
		readNext('{8'ha5, 8'h5a});
		// last ram byte, then a dropped reserved write
		writeAt(8'h7f, 8'hef, '{8'he1, 8'h77});
		setPtr(8'h7f, 8'hef);
		mst_u.busStop();
		readNext('{8'he1, 8'h00});
		// clock registers through the top, wrapping to zero
		writeAt(8'h7f, 8'hfb, '{8'h23, 8'h05, 8'h31, 8'h12, 8'h99, 8'h3c, 8'hc3});
		setPtr(8'h7f, 8'hfb);
		readNext('{8'h23, 8'h05, 8'h31, 8'h12, 8'h99, 8'h3c});
		readNext('{8'hc3});
		// frozen counters hold across a tick, then one tick rolls the whole calendar
		writeAt(8'h7f, 8'hf8, '{8'h80, 8'h59, 8'h59, 8'h23, 8'h05, 8'h31, 8'h12, 8'h99});
		writeAt(8'h7f, 8'hf7, '{8'h99});
		repeat (1400) @(posedge clock);
		setPtr(8'h7f, 8'hf7);
		readNext('{8'h99});
		writeAt(8'h7f, 8'hf8, '{8'h00});
		repeat (1400) @(posedge clock);
		setPtr(8'h7f, 8'hf9);
		readNext('{8'h00, 8'h00, 8'h00, 8'h06, 8'h01, 8'h01, 8'h00});
		// foreign address is left alone
		mst_u.busStart();
		sendB(8'ha0, 1'b1);
		mst_u.busStop();
		// supply loss in mid-write clears the pointer and blocks the bus
		setPtr(8'h00, 8'h05);
		supplyOk <= 1'b0;
		repeat (8) @(posedge clock);
		#1 flag(writeProtect, 1'b1);
		sendB(8'h55, 1'b1);
		mst_u.busStop();
		supplyOk <= 1'b1;
		for (cnt = 0; cnt < 200 && writeProtect !== 1'b0; cnt++) @(negedge clock);
		flag(cnt >= RCY, 1'b1);
		flag(cnt <= RCY + 12, 1'b1);
		repeat (8) @(posedge clock);
		readNext('{8'h3c});
		printVerdict();
	end
endmodule : tb
`default_nettype wire
